// *** hdl/twowire_host.sv ***
/*
  Bus master that drives the temperature sensor over SCL and SDA.
  Assumes external pull-ups resolve the open-drain pins; one command at a time.
*/
`timescale 1ns/1ps
`include "twowire_host_params.svh"

// How it works
// - SCL kept between 1 and 400 kHz; SCL_HZ is not checked against SCL_MIN_HZ or SCL_MAX_HZ.
// - 16-bit values move upper byte first.
// - Start: SDA falls while SCL high.
// - Stop: SDA rises while SCL high.
// - First written byte is the pointer.
// - Pointer change: write pointer, restart, read.
// - Master ends read with nack then stop.
// - SDA stable while SCL high.
// - Eight data clocks, then one ack clock.
// - Master decides byte count.
// - Ack holds SDA low; last read nacks.
module twowire_host
  import twowire_host_pkg::*;
#(
  parameter int unsigned SCL_HZ = `SCL_DEFAULT_HZ
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Command port
  input  wire logic        cmd_valid,
  input  wire host_cmd_t   cmd_op,
  input  wire logic [1:0]  cmd_addr_sel,
  input  wire logic [7:0]  cmd_pointer,
  input  wire logic [15:0] cmd_wdata,
  output logic             cmd_ready,
  // Answer port
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             rsp_nack,
  // Bus pins
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  localparam int unsigned QUARTER = `CLK_FREQ_HZ / (4 * SCL_HZ);

  // ==========================================================================
  // Bit phases and sequencer
  typedef enum logic [2:0] {S_IDLE, S_START, S_BIT, S_STOP, S_DONE} state_t;

  state_t      state_reg, state_next;
  logic [1:0]  phase_reg, phase_next;
  logic [3:0]  bit_reg, bit_next;
  logic [2:0]  byte_reg, byte_next;
  logic [2:0]  nbytes_reg, nbytes_next;
  logic [2:0]  restart_at_reg, restart_at_next;
  logic [7:0]  tx_reg, tx_next;
  logic [7:0]  rx_reg, rx_next;
  logic        rd_reg, rd_next;
  host_cmd_t   op_reg, op_next;
  logic [6:0]  addr_reg, addr_next;
  logic [7:0]  ptr_reg, ptr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        nack_reg, nack_next;
  logic        scl_reg, scl_next;
  logic        sdalow_reg, sdalow_next;
  logic        ready_next, rvalid_next;
  logic        sda_meta, sda_sync;
  logic        tick;

  scl_tick_gen #(.QUARTER_CYCLES(QUARTER)) u_tick (
    .clk (clk),
    .rst (rst),
    .run (state_reg != S_IDLE && state_reg != S_DONE),
    .tick(tick)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
    end
  end

  // Byte k of the frame; the read address byte follows a restart.
  function automatic logic [7:0] frame_byte(input host_cmd_t op, input logic [2:0] k,
                                            input logic [6:0] a, input logic [7:0] p,
                                            input logic [15:0] w);
    logic [7:0] b;
    b = 8'hFF;
    unique case (op)
      CMD_GENERAL_RESET:  b = (k == 3'd0) ? {`GENERAL_CALL_ADDR, 1'b0}
                                          : `GENERAL_RESET_CMD;
      CMD_ALERT_RESPONSE: b = {`ALERT_RESPONSE_ADDR, 1'b1};
      CMD_SET_POINTER:    b = (k == 3'd0) ? {a, 1'b0} : p;
      CMD_WRITE_REG: begin
        if (k == 3'd0) b = {a, 1'b0};
        else if (k == 3'd1) b = p;
        else if (k == 3'd2) b = w[15:8];
        else b = w[7:0];
      end
      CMD_READ_REG: begin
        if (k == 3'd0) b = {a, 1'b0};
        else if (k == 3'd1) b = p;
        else b = {a, 1'b1};
      end
    endcase
    return b;
  endfunction : frame_byte

  always_comb begin
    state_next      = state_reg;
    phase_next      = phase_reg;
    bit_next        = bit_reg;
    byte_next       = byte_reg;
    nbytes_next     = nbytes_reg;
    restart_at_next = restart_at_reg;
    tx_next         = tx_reg;
    rx_next         = rx_reg;
    rd_next         = rd_reg;
    op_next         = op_reg;
    addr_next       = addr_reg;
    ptr_next        = ptr_reg;
    wdata_next      = wdata_reg;
    rdata_next      = rdata_reg;
    nack_next       = nack_reg;
    scl_next        = scl_reg;
    sdalow_next     = sdalow_reg;
    ready_next      = 1'b0;
    rvalid_next     = 1'b0;
    unique case (state_reg)
      S_IDLE: begin
        ready_next = 1'b1;
        if (cmd_valid && cmd_ready) begin
          ready_next = 1'b0;
          op_next    = cmd_op;
          addr_next  = {`SENSOR_ADDR_PREFIX, cmd_addr_sel};
          ptr_next   = cmd_pointer;
          wdata_next = cmd_wdata;
          nack_next  = 1'b0;
          rdata_next = 16'h0000;
          // Frame sizes in bytes including address bytes; register reads add three to the pointer write.
          unique case (cmd_op)
            CMD_SET_POINTER:    nbytes_next = 3'd2;
            CMD_WRITE_REG:      nbytes_next = 3'd4;
            CMD_READ_REG:       nbytes_next = 3'd5;
            CMD_ALERT_RESPONSE: nbytes_next = 3'd2;
            CMD_GENERAL_RESET:  nbytes_next = 3'd2;
          endcase
          restart_at_next = (cmd_op == CMD_READ_REG) ? 3'd2 : 3'd7;
          byte_next  = 3'd0;
          phase_next = 2'd0;
          state_next = S_START;
        end
      end
      S_START: if (tick) begin
        // Quarters: SDA/SCL high, SDA low, SCL low; then first bit.
        phase_next = phase_reg + 2'd1;
        unique case (phase_reg)
          2'd0: begin sdalow_next = 1'b0; scl_next = 1'b1; end
          2'd1: sdalow_next = 1'b1;
          2'd2: scl_next = 1'b0;
          2'd3: begin
            tx_next    = frame_byte(op_reg, byte_reg, addr_reg, ptr_reg, wdata_reg);
            rd_next    = 1'b0;
            bit_next   = 4'd0;
            state_next = S_BIT;
          end
        endcase
      end
      S_BIT: if (tick) begin
        phase_next = phase_reg + 2'd1;
        unique case (phase_reg)
          2'd0: begin
            // SDA only changes while SCL is low.
            if (bit_reg < 4'd8) sdalow_next = rd_reg ? 1'b0 : !tx_reg[7];
            else if (rd_reg) sdalow_next = (byte_reg != nbytes_reg - 3'd1);
            else sdalow_next = 1'b0;
          end
          2'd1: scl_next = 1'b1;
          2'd2: begin
            if (bit_reg < 4'd8) begin
              rx_next = {rx_reg[6:0], sda_sync};
              tx_next = {tx_reg[6:0], 1'b1};
            end else if (!rd_reg && sda_sync) begin
              nack_next = 1'b1;
            end
          end
          2'd3: begin
            scl_next = 1'b0;
            if (bit_reg < 4'd8) begin
              bit_next = bit_reg + 4'd1;
            end else begin
              if (rd_reg) rdata_next = {rdata_reg[7:0], rx_reg};
              if (op_reg == CMD_ALERT_RESPONSE && byte_reg == 3'd1) begin
                rdata_next = {8'h00, rx_reg};
              end
              byte_next = byte_reg + 3'd1;
              bit_next  = 4'd0;
              if (nack_next || byte_reg + 3'd1 == nbytes_reg) begin
                // SDA is pulled a quarter later, so it never moves with the SCL edge.
                state_next  = S_STOP;
              end else if (byte_reg + 3'd1 == restart_at_reg) begin
                sdalow_next = 1'b0;
                state_next  = S_START;
              end else begin
                tx_next = frame_byte(op_reg, byte_reg + 3'd1, addr_reg, ptr_reg, wdata_reg);
                rd_next = (op_reg == CMD_READ_REG && byte_reg >= 3'd2) ||
                          (op_reg == CMD_ALERT_RESPONSE);
              end
            end
          end
        endcase
      end
      S_STOP: if (tick) begin
        phase_next = phase_reg + 2'd1;
        unique case (phase_reg)
          2'd0: sdalow_next = 1'b1;
          2'd1: scl_next = 1'b1;
          2'd2: sdalow_next = 1'b0;
          2'd3: state_next = S_DONE;
        endcase
      end
      S_DONE: begin
        rvalid_next = 1'b1;
        state_next  = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg      <= S_IDLE;
      phase_reg      <= 2'd0;
      bit_reg        <= 4'd0;
      byte_reg       <= 3'd0;
      nbytes_reg     <= 3'd0;
      restart_at_reg <= 3'd7;
      tx_reg         <= 8'hFF;
      rx_reg         <= 8'h00;
      rd_reg         <= 1'b0;
      op_reg         <= CMD_SET_POINTER;
      addr_reg       <= 7'h00;
      ptr_reg        <= 8'h00;
      wdata_reg      <= 16'h0000;
      rdata_reg      <= 16'h0000;
      nack_reg       <= 1'b0;
      scl_reg        <= 1'b1;
      sdalow_reg     <= 1'b0;
      cmd_ready      <= 1'b0;
      rsp_valid      <= 1'b0;
      rsp_rdata      <= 16'h0000;
      rsp_nack       <= 1'b0;
    end else begin
      state_reg      <= state_next;
      phase_reg      <= phase_next;
      bit_reg        <= bit_next;
      byte_reg       <= byte_next;
      nbytes_reg     <= nbytes_next;
      restart_at_reg <= restart_at_next;
      tx_reg         <= tx_next;
      rx_reg         <= rx_next;
      rd_reg         <= rd_next;
      op_reg         <= op_next;
      addr_reg       <= addr_next;
      ptr_reg        <= ptr_next;
      wdata_reg      <= wdata_next;
      rdata_reg      <= rdata_next;
      nack_reg       <= nack_next;
      scl_reg        <= scl_next;
      sdalow_reg     <= sdalow_next;
      cmd_ready      <= ready_next;
      rsp_valid      <= rvalid_next;
      rsp_rdata      <= rvalid_next ? rdata_reg : rsp_rdata;
      rsp_nack       <= rvalid_next ? nack_reg : rsp_nack;
    end
  end

  // Open drain: drive only low, release for high.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
    end else begin
      scl_oe <= !scl_next;
      sda_oe <= sdalow_next;
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  scl_open_drain_a: assert property (@(posedge clk) disable iff (rst)
    scl_o == 1'b0) else $error("scl driven high");
  sda_stable_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg == S_BIT && !scl_oe && $past(!scl_oe)) |-> $stable(sda_oe))
    else $error("sda changed while scl high");
  start_shape_a: assert property (@(posedge clk) disable iff (rst)
    ($rose(sda_oe) && !scl_oe) |-> state_reg == S_START)
    else $error("sda fell with scl high outside start");
  stop_shape_a: assert property (@(posedge clk) disable iff (rst)
    ($fell(sda_oe) && !scl_oe) |-> state_reg == S_STOP)
    else $error("sda rose with scl high outside stop");
  addr_prefix_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg != S_IDLE) |-> addr_reg[6:2] == `SENSOR_ADDR_PREFIX)
    else $error("bad address prefix");
  done_answer_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg == S_DONE) |=> rsp_valid && cmd_ready == 1'b0)
    else $error("answer missing after frame");
  idle_release_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg == S_IDLE && $past(state_reg) == S_IDLE) |-> !sda_oe && !scl_oe)
    else $error("bus not released when idle");
  bit_count_a: assert property (@(posedge clk) disable iff (rst)
    bit_reg <= 4'd8) else $error("more than nine clocks per byte");

endmodule : twowire_host

// *** hdl/twowire_host_params.svh ***
/*
  Constants for the two-wire host controller that talks to the temperature sensor.
  Assumes a 200 MHz system clock; included by both module files.
*/
`ifndef TWOWIRE_HOST_PARAMS_SVH
`define TWOWIRE_HOST_PARAMS_SVH

`define CLK_FREQ_HZ        200000000
`define SCL_MIN_HZ         1000
`define SCL_MAX_HZ         400000
`define SCL_DEFAULT_HZ     400000
`define SENSOR_ADDR_PREFIX 5'h12
`define GENERAL_CALL_ADDR  7'h00
`define GENERAL_RESET_CMD  8'h06
`define ALERT_RESPONSE_ADDR 7'h0C

`endif

// *** hdl/twowire_host_pkg.sv ***
/*
  Types shared by the two-wire host controller files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package twowire_host_pkg;

  // ==========================================================================
  // Commands
  typedef enum logic [2:0] {
    CMD_SET_POINTER,
    CMD_WRITE_REG,
    CMD_READ_REG,
    CMD_ALERT_RESPONSE,
    CMD_GENERAL_RESET
  } host_cmd_t;

endpackage : twowire_host_pkg

// *** hdl/scl_tick_gen.sv ***
/*
  Divider that produces the quarter-period enable for the SCL waveform.
  Assumes one system clock; the quarter count is fixed by parameter.
*/
`timescale 1ns/1ps
`include "twowire_host_params.svh"

module scl_tick_gen #(
  parameter int unsigned QUARTER_CYCLES = 125
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic run,
  output logic      tick
);

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        tick_next;

  always_comb begin
    count_next = count_reg;
    tick_next  = 1'b0;
    if (!run) begin
      count_next = 16'h0000;
    end else if (count_reg == 16'(QUARTER_CYCLES - 1)) begin
      count_next = 16'h0000;
      tick_next  = 1'b1;
    end else begin
      count_next = count_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 16'h0000;
      tick      <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick      <= tick_next;
    end
  end

endmodule : scl_tick_gen

// *** dv/sensor_model.sv ***
/*
  Behavioural model of the temperature sensor's two-wire slave port.
  Assumes the bench resolves SCL and SDA with pull-ups and feeds the resolved levels back.
*/
`timescale 1ns/1ps

module sensor_model #(
  parameter logic [15:0] RESET_BASE = 16'h8000,
  parameter int          LOAD_NS    = 1500000
) (
  // Bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_pull,
  // Pin strap and alert state
  input  wire logic [1:0] sel,
  input  wire logic       alert_on,
  input  wire logic       alert_high,
  input  wire logic       threshold_window_select
);
  localparam logic [7:0] CONFIG_PTR = 8'h01;
  logic [15:0] regs [0:15];
  logic [7:0]  ptr;
  logic        restart;
  logic        alert_cleared;
  realtime     load_until;

  // ==========================================================================
  // Byte level helpers
  task automatic load_defaults();
    for (int i = 0; i < 16; i++) begin
      regs[i] = RESET_BASE + 16'(i);
    end
    ptr = 8'h00;
    // Register writes are dropped until the reload has finished.
    load_until = $realtime + LOAD_NS;
  endtask : load_defaults

  task automatic get_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
  endtask : get_byte

  task automatic ack();
    @(negedge scl);
    sda_pull = 1'b1;
    @(negedge scl);
    sda_pull = 1'b0;
  endtask : ack

  // Only SDA is ever pulled; the model has no way to touch SCL.
  task automatic send_byte(input logic [7:0] b, output logic mack);
    for (int i = 7; i >= 0; i--) begin
      sda_pull = ~b[i];
      @(negedge scl);
    end
    sda_pull = 1'b0;
    @(posedge scl);
    mack = ~sda;
    @(negedge scl);
  endtask : send_byte

  // ==========================================================================
  // Frame decoding
  task automatic serve();
    logic [7:0] a;
    logic [7:0] p;
    logic [7:0] hi;
    logic [7:0] lo;
    logic       m;
    get_byte(a);
    if (a[7:1] == {5'h12, sel}) begin
      ack();
      if (a[0]) begin
        send_byte(regs[ptr[3:0]][15:8], m);
        if (m) send_byte(regs[ptr[3:0]][7:0], m);
        if (ptr == CONFIG_PTR && !threshold_window_select) alert_cleared = 1'b1;
      end else begin
        get_byte(p);
        ptr = p;
        ack();
        forever begin
          get_byte(hi);
          ack();
          get_byte(lo);
          ack();
          if ($realtime >= load_until) regs[ptr[3:0]] = {hi, lo};
        end
      end
    end else if (a == 8'h00) begin
      ack();
      get_byte(p);
      ack();
      if (p == 8'h06) load_defaults();
    end else if (a == 8'h19 && alert_on && !alert_cleared) begin
      ack();
      send_byte({5'h12, sel, alert_high}, m);
      if (!threshold_window_select) alert_cleared = 1'b1;
    end
  endtask : serve

  // A stop ends the frame; a repeated start begins a new one at once.
  initial begin
    sda_pull = 1'b0;
    restart  = 1'b0;
    alert_cleared = 1'b0;
    load_defaults();
    forever begin
      if (!restart) @(negedge sda iff scl === 1'b1);
      restart = 1'b0;
      // A new alert event rearms the response once the bench drops the old one.
      if (!alert_on) alert_cleared = 1'b0;
      fork : frame
        serve();
        @(posedge sda iff scl === 1'b1);
        begin
          @(negedge sda iff scl === 1'b1);
          restart = 1'b1;
        end
      join_any
      disable frame;
      sda_pull = 1'b0;
    end
  end
endmodule : sensor_model

// *** dv/test_twowire_host.sv ***
/*
  Self-checking bench for the two-wire host controller against the sensor model.
  Assumes the 400 kHz default bit rate; lines are resolved here with pull-ups.
*/
`timescale 1ns/1ps

module test_twowire_host;
  import twowire_host_pkg::*;

  localparam logic [15:0] RESET_BASE = 16'h8000;

  logic        clk;
  logic        rst;
  logic        cmd_valid;
  host_cmd_t   cmd_op;
  logic [1:0]  cmd_addr_sel;
  logic [7:0]  cmd_pointer;
  logic [15:0] cmd_wdata;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [15:0] rsp_rdata;
  logic        rsp_nack;
  logic        scl_o;
  logic        scl_oe;
  logic        sda_o;
  logic        sda_oe;
  logic        scl_line;
  logic        sda_line;
  logic        model_pull;
  logic [1:0]  pin_sel;
  logic        alert_on;
  logic        alert_high;
  logic        threshold_window_select;
  logic [15:0] got_d;
  logic        got_n;
  logic [1:0]  s;
  logic [7:0]  p;
  logic [15:0] w;
  int          fail_count;
  int          tests_run;

  assign scl_line = scl_oe ? scl_o : 1'b1;
  assign sda_line = (sda_oe ? sda_o : 1'b1) & ~model_pull;

  twowire_host #(.SCL_HZ(400000)) dut (
    .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr_sel(cmd_addr_sel), .cmd_pointer(cmd_pointer), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_nack(rsp_nack), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe)
  );

  // The reload is shortened so that the first write lands after it.
  sensor_model #(.RESET_BASE(RESET_BASE), .LOAD_NS(20000)) model (
    .scl(scl_line), .sda(sda_line), .sda_pull(model_pull), .sel(pin_sel),
    .alert_on(alert_on), .alert_high(alert_high),
    .threshold_window_select(threshold_window_select)
  );

  always #2.5 clk = ~clk;

  // ==========================================================================
  // Expectations and comparisons
  function automatic logic [15:0] exp_alert(input logic [1:0] sl, input logic h);
    return {8'h00, 5'h12, sl, h};
  endfunction : exp_alert

  // A window-mode winner drops its alert; a threshold-mode alert stays up.
  function automatic logic exp_repeat_nack(input logic therm);
    return !therm;
  endfunction : exp_repeat_nack

  function automatic logic [15:0] exp_reset(input logic [7:0] pt);
    return RESET_BASE + {8'h00, pt};
  endfunction : exp_reset

  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Command driver: fields held until the edge that sees ready high.
  task automatic run_cmd(input host_cmd_t op, input logic [1:0] sl, input logic [7:0] pt,
                         input logic [15:0] wd);
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    cmd_op       = op;
    cmd_addr_sel = sl;
    cmd_pointer  = pt;
    cmd_wdata    = wd;
    cmd_valid    = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40000) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
    got_d = rsp_rdata;
    got_n = rsp_nack;
  endtask : run_cmd

  // ==========================================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = CMD_SET_POINTER;
    cmd_addr_sel = 2'h0;
    cmd_pointer = 8'h00;
    cmd_wdata = 16'h0000;
    pin_sel = 2'h0;
    alert_on = 1'b0;
    alert_high = 1'b0;
    threshold_window_select = 1'b0;
    fail_count = 0;
    tests_run = 0;
    void'($urandom(32'hB5DA8A6C));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    s = 2'($urandom);
    p = 8'($urandom_range(1, 14));
    w = 16'($urandom);
    pin_sel = s;
    run_cmd(CMD_WRITE_REG, s, p, w);
    chk_flag(got_n, 1'b0);
    run_cmd(CMD_READ_REG, s, p, 16'h0000);
    chk_data(got_d, w);
    chk_flag(got_n, 1'b0);
    run_cmd(CMD_SET_POINTER, s ^ 2'h1, p, 16'h0000);
    chk_flag(got_n, 1'b1);
    run_cmd(CMD_ALERT_RESPONSE, s, 8'h00, 16'h0000);
    chk_flag(got_n, 1'b1);
    alert_on = 1'b1;
    alert_high = 1'($urandom);
    threshold_window_select = 1'($urandom);
    run_cmd(CMD_ALERT_RESPONSE, s, 8'h00, 16'h0000);
    chk_data(got_d, exp_alert(s, alert_high));
    run_cmd(CMD_ALERT_RESPONSE, s, 8'h00, 16'h0000);
    chk_flag(got_n, exp_repeat_nack(threshold_window_select));
    alert_on = 1'b0;
    run_cmd(CMD_GENERAL_RESET, s, 8'h00, 16'h0000);
    chk_flag(got_n, 1'b0);
    run_cmd(CMD_READ_REG, s, p, 16'h0000);
    chk_data(got_d, exp_reset(p));
    chk_flag(scl_line & sda_line, 1'b1);
    wrap_up();
  end

  // Eight frames at 400 kHz take about 104k cycles; this allows half again as much.
  initial begin
    #800000;
    fail_count++;
    wrap_up();
  end
endmodule : test_twowire_host
